// ==== rtl/mfa_top.sv ====
// motor protection, alarm latch, coded led and speed command select
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module mfa_top #(
    parameter int unsigned LED_ON_CYC    = mfa_pkg::LED_ON_CYC,
    parameter int unsigned LED_OFF_CYC   = mfa_pkg::LED_OFF_CYC,
    parameter int unsigned GROUP_GAP_CYC = mfa_pkg::GROUP_GAP_CYC,
    parameter int unsigned OVERLOAD_CYC  = mfa_pkg::OVERLOAD_CYC,
    parameter int unsigned CHURN_WIN_CYC = mfa_pkg::CHURN_WIN_CYC
) (
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    // control inputs, 1 = on
    input  wire logic        run_ramp_i,
    input  wire logic        run_or_hard_stop_input_i,
    input  wire logic        dir_cw_i,
    input  wire logic        speed_source_select_i,
    input  wire logic        fault_clear_i,
    // measured conditions
    input  wire logic        load_over_rated_i,
    input  wire logic        sensor_lost_i,
    input  wire logic [15:0] supply_mv_i,
    input  wire logic [12:0] speed_meas_i,
    input  wire logic [12:0] ext_speed_mv_i,
    // motor side
    output logic             fault_ok_o,
    output logic             motor_run_o,
    output logic             hard_stop_o,
    output logic             dir_cw_o,
    output logic [12:0]      speed_cmd_o,
    output logic             led_o,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o
);

    typedef struct packed {
        logic        waitreq;
        logic [31:0] rdata;
        logic [11:0] spd_int;
        logic [2:0]  code;
        logic        ok;
        logic [31:0] ovl_tmr;
        logic [31:0] win_tmr;
        logic [4:0]  churn;
        logic [2:0]  prev_in;
        logic        clr_prev;
        logic        run;
        logic        hard_stop;
        logic        dir;
        logic [12:0] spd_cmd;
    } mfa_state_t;

    mfa_state_t s_r;
    mfa_state_t s_nxt;

    // ------------------------------------------------------------
    // fault detection, combinational
    // ------------------------------------------------------------
    logic [2:0]  det_code;
    logic [28:0] ext_prod;
    logic [12:0] ext_rpm;
    logic [12:0] sel_rpm;
    logic        clr_accept;
    logic        both_run;
    logic        in_changed;
    logic        ovl_timeout;
    logic        churn_hit;

    assign both_run    = run_ramp_i & run_or_hard_stop_input_i;
    assign in_changed  = ({run_ramp_i, run_or_hard_stop_input_i, dir_cw_i} != s_r.prev_in);
    assign ovl_timeout = load_over_rated_i && (s_r.ovl_tmr >= 32'(OVERLOAD_CYC - 1));
    assign churn_hit   = in_changed && (s_r.churn >= mfa_pkg::CHURN_LIMIT - 5'h1);

    always_comb begin
        // lowest code wins when several appear in the same cycle
        if (ovl_timeout || churn_hit) begin
            det_code = mfa_pkg::FLT_OVERLOAD;
        end else if (sensor_lost_i) begin
            det_code = mfa_pkg::FLT_SENSOR;
        end else if (supply_mv_i >= mfa_pkg::OVERV_MV) begin
            det_code = mfa_pkg::FLT_OVERVOLT;
        end else if (supply_mv_i <= mfa_pkg::UNDERV_MV) begin
            det_code = mfa_pkg::FLT_UNDERVLT;
        end else if (speed_meas_i > mfa_pkg::OVERSPD_RPM) begin
            det_code = mfa_pkg::FLT_OVERSPD;
        end else begin
            det_code = mfa_pkg::FLT_NONE;
        end
    end

    // clear is taken on the off edge of the pulse, motor at rest
    assign clr_accept = s_r.clr_prev && !fault_clear_i && !both_run
                        && (speed_meas_i == 13'h0);

    // ------------------------------------------------------------
    // speed command select and clamp
    // ------------------------------------------------------------
    assign ext_prod = ext_speed_mv_i * mfa_pkg::EXT_SCALE;
    assign ext_rpm  = ext_prod[28:16];

    always_comb begin
        // open select input is pulled off externally, so ext wins
        if (speed_source_select_i) begin
            sel_rpm = {1'b0, s_r.spd_int};
        end else begin
            sel_rpm = ext_rpm;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt          = s_r;
        s_nxt.prev_in  = {run_ramp_i, run_or_hard_stop_input_i, dir_cw_i};
        s_nxt.clr_prev = fault_clear_i;

        // overload timing: sustained over-torque
        if (load_over_rated_i && s_r.ok) begin
            s_nxt.ovl_tmr = s_r.ovl_tmr + 32'h1;
        end else begin
            s_nxt.ovl_tmr = 32'h0;
        end

        // churn window: too many run/direction changes per window
        if (s_r.win_tmr >= 32'(CHURN_WIN_CYC - 1)) begin
            s_nxt.win_tmr = 32'h0;
            s_nxt.churn   = 5'h0;
        end else begin
            s_nxt.win_tmr = s_r.win_tmr + 32'h1;
            if (in_changed && s_r.ok && s_r.churn != 5'h1f) begin
                s_nxt.churn = s_r.churn + 5'h1;
            end
        end

        // alarm latch; a fault in the clear cycle still wins
        if (s_r.ok) begin
            if (det_code != mfa_pkg::FLT_NONE) begin
                s_nxt.ok   = 1'b0;
                s_nxt.code = det_code;
            end
        end else if (clr_accept) begin
            if (det_code != mfa_pkg::FLT_NONE) begin
                s_nxt.code = det_code;
            end else begin
                s_nxt.ok    = 1'b1;
                s_nxt.code  = mfa_pkg::FLT_NONE;
                s_nxt.churn = 5'h0;
            end
        end

        // motor drive: brake has precedence, alarm forces a hard stop
        if (!s_nxt.ok) begin
            s_nxt.run       = 1'b0;
            s_nxt.hard_stop = 1'b1;
        end else begin
            s_nxt.run       = both_run;
            s_nxt.hard_stop = !run_or_hard_stop_input_i;
        end
        s_nxt.dir = dir_cw_i;

        // clamp keeps a zero internal setting at the lowest speed
        if (sel_rpm < mfa_pkg::SPD_MIN_RPM) begin
            s_nxt.spd_cmd = mfa_pkg::SPD_MIN_RPM;
        end else if (sel_rpm > mfa_pkg::SPD_MAX_RPM) begin
            s_nxt.spd_cmd = mfa_pkg::SPD_MAX_RPM;
        end else begin
            s_nxt.spd_cmd = sel_rpm;
        end

        // bus slave: one wait cycle, then answer for exactly one cycle
        s_nxt.waitreq = 1'b1;
        if ((avs_read_i || avs_write_i) && s_r.waitreq) begin
            s_nxt.waitreq = 1'b0;
            if (avs_read_i) begin
                case (avs_address_i)
                    mfa_pkg::REG_CTRL: begin
                        s_nxt.rdata = {20'h0, s_r.spd_int};
                    end
                    mfa_pkg::REG_STATUS: begin
                        s_nxt.rdata = {27'h0, s_r.code, !s_r.ok, s_r.ok};
                    end
                    mfa_pkg::REG_SPEED: begin
                        s_nxt.rdata = {19'h0, s_r.spd_cmd};
                    end
                    default: begin
                        s_nxt.rdata = 32'h0;
                    end
                endcase
            end else if (avs_address_i == mfa_pkg::REG_CTRL) begin
                if (avs_byteenable_i[0]) begin
                    s_nxt.spd_int[7:0] = avs_writedata_i[7:0];
                end
                if (avs_byteenable_i[1]) begin
                    s_nxt.spd_int[11:8] = avs_writedata_i[11:8];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            s_r.waitreq   <= 1'b1;
            s_r.rdata     <= 32'h0;
            s_r.spd_int   <= mfa_pkg::SPD_INT_RST;
            s_r.code      <= mfa_pkg::FLT_NONE;
            s_r.ok        <= 1'b1;
            s_r.ovl_tmr   <= 32'h0;
            s_r.win_tmr   <= 32'h0;
            s_r.churn     <= 5'h0;
            s_r.prev_in   <= 3'h0;
            s_r.clr_prev  <= 1'b0;
            s_r.run       <= 1'b0;
            s_r.hard_stop <= 1'b1;
            s_r.dir       <= 1'b0;
            s_r.spd_cmd   <= mfa_pkg::SPD_MIN_RPM;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // coded alarm led
    // ------------------------------------------------------------
    mfa_blink #(
        .ON_CYC  (LED_ON_CYC),
        .OFF_CYC (LED_OFF_CYC),
        .GAP_CYC (GROUP_GAP_CYC)
    ) u_blink (
        .mclk_i   (mclk_i),
        .srst_i   (srst_i),
        .active_i (!s_r.ok),
        .count_i  (s_r.code),
        .led_o    (led_o)
    );

    assign fault_ok_o        = s_r.ok;
    assign motor_run_o       = s_r.run;
    assign hard_stop_o       = s_r.hard_stop;
    assign dir_cw_o          = s_r.dir;
    assign speed_cmd_o       = s_r.spd_cmd;
    assign avs_readdata_o    = s_r.rdata;
    assign avs_waitrequest_o = s_r.waitreq;

endmodule : mfa_top

// ==== rtl/mfa_pkg.sv ====
// constants shared by the motor fault, alarm and speed select block
package mfa_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_KHZ       = 200000;
    localparam int unsigned LED_ON_MS     = 300;
    localparam int unsigned LED_OFF_MS    = 300;
    localparam int unsigned GROUP_GAP_MS  = 1500;
    localparam int unsigned OVERLOAD_MS   = 5000;
    localparam int unsigned CHURN_WIN_MS  = 1000;
    localparam int unsigned LED_ON_CYC    = LED_ON_MS * CLK_KHZ;
    localparam int unsigned LED_OFF_CYC   = LED_OFF_MS * CLK_KHZ;
    localparam int unsigned GROUP_GAP_CYC = GROUP_GAP_MS * CLK_KHZ;
    localparam int unsigned OVERLOAD_CYC  = OVERLOAD_MS * CLK_KHZ;
    localparam int unsigned CHURN_WIN_CYC = CHURN_WIN_MS * CLK_KHZ;
    localparam logic [4:0]  CHURN_LIMIT   = 5'h10;

    // ------------------------------------------------------------
    // fault codes, equal to the blink count of each group
    // ------------------------------------------------------------
    localparam logic [2:0] FLT_NONE     = 3'h0;
    localparam logic [2:0] FLT_OVERLOAD = 3'h2;
    localparam logic [2:0] FLT_SENSOR   = 3'h3;
    localparam logic [2:0] FLT_OVERVOLT = 3'h4;
    localparam logic [2:0] FLT_UNDERVLT = 3'h5;
    localparam logic [2:0] FLT_OVERSPD  = 3'h6;

    // ------------------------------------------------------------
    // supply and speed limits
    // ------------------------------------------------------------
    localparam int unsigned NOMINAL_MV   = 24000;
    localparam int unsigned OVERV_PCT    = 15;
    localparam int unsigned UNDERV_PCT   = 25;
    localparam logic [15:0] OVERV_MV     = 16'(NOMINAL_MV * (100 + OVERV_PCT) / 100);
    localparam logic [15:0] UNDERV_MV    = 16'(NOMINAL_MV * (100 - UNDERV_PCT) / 100);
    localparam logic [12:0] OVERSPD_RPM  = 13'h0dac;
    localparam logic [12:0] SPD_MIN_RPM  = 13'h0064;
    localparam logic [12:0] SPD_MAX_RPM  = 13'h0bb8;
    localparam logic [11:0] SPD_INT_RST  = 12'h000;
    // 0..5000 mV maps to 0..3000 r/min: scale 0.6 in 16-bit fraction
    localparam logic [15:0] EXT_SCALE    = 16'h999a;

    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_SPEED  = 4'h8;

endpackage : mfa_pkg

// ==== rtl/mfa_blink.sv ====
// coded alarm led blinker: groups of lit/dark pulses with a pause
`timescale 1ns/1ps
module mfa_blink #(
    parameter int unsigned ON_CYC  = 60,
    parameter int unsigned OFF_CYC = 60,
    parameter int unsigned GAP_CYC = 300
) (
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic       active_i,
    input  wire logic [2:0] count_i,
    output logic            led_o
);

    typedef enum logic [3:0] {
        BL_IDLE = 4'h1,
        BL_ON   = 4'h2,
        BL_OFF  = 4'h4,
        BL_GAP  = 4'h8
    } mfa_bl_st_t;

    typedef struct packed {
        mfa_bl_st_t  st;
        logic [31:0] tmr;
        logic [2:0]  left;
        logic        led;
    } mfa_bl_t;

    mfa_bl_t s_r;
    mfa_bl_t s_nxt;

    always_comb begin
        s_nxt     = s_r;
        s_nxt.tmr = s_r.tmr - 32'h1;
        case (s_r.st)
            BL_IDLE: begin
                s_nxt.tmr = 32'h0;
                if (active_i) begin
                    s_nxt.st   = BL_ON;
                    s_nxt.tmr  = 32'(ON_CYC - 1);
                    s_nxt.left = count_i;
                    s_nxt.led  = 1'b1;
                end
            end
            BL_ON: begin
                if (s_r.tmr == 32'h0) begin
                    s_nxt.st   = BL_OFF;
                    s_nxt.tmr  = 32'(OFF_CYC - 1);
                    s_nxt.left = s_r.left - 3'h1;
                    s_nxt.led  = 1'b0;
                end
            end
            BL_OFF: begin
                if (s_r.tmr == 32'h0) begin
                    if (s_r.left == 3'h0) begin
                        s_nxt.st  = BL_GAP;
                        s_nxt.tmr = 32'(GAP_CYC - 1);
                    end else begin
                        s_nxt.st  = BL_ON;
                        s_nxt.tmr = 32'(ON_CYC - 1);
                        s_nxt.led = 1'b1;
                    end
                end
            end
            BL_GAP: begin
                if (s_r.tmr == 32'h0) begin
                    s_nxt.st   = BL_ON;
                    s_nxt.tmr  = 32'(ON_CYC - 1);
                    s_nxt.left = count_i;
                    s_nxt.led  = 1'b1;
                end
            end
            default: begin
                s_nxt.st  = BL_IDLE;
                s_nxt.led = 1'b0;
            end
        endcase
        // clearing the alarm stops the pattern at once, mid-blink
        if (!active_i) begin
            s_nxt.st   = BL_IDLE;
            s_nxt.tmr  = 32'h0;
            s_nxt.left = 3'h0;
            s_nxt.led  = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            s_r.st   <= BL_IDLE;
            s_r.tmr  <= 32'h0;
            s_r.left <= 3'h0;
            s_r.led  <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign led_o = s_r.led;

endmodule : mfa_blink

// ==== verification/mfa_checker.sv ====
// concurrent checks on the ports of the motor fault, alarm and speed select block
`timescale 1ns/1ps
module mfa_checker #(
    parameter int unsigned LED_ON_CYC    = 4,
    parameter int unsigned LED_OFF_CYC   = 4,
    parameter int unsigned GROUP_GAP_CYC = 12
) (
    input wire logic        mclk_i,
    input wire logic        srst_i,
    input wire logic        run_ramp_i,
    input wire logic        run_or_hard_stop_input_i,
    input wire logic        fault_clear_i,
    input wire logic        sensor_lost_i,
    input wire logic [15:0] supply_mv_i,
    input wire logic [12:0] speed_meas_i,
    input wire logic        fault_ok_o,
    input wire logic        motor_run_o,
    input wire logic        hard_stop_o,
    input wire logic [12:0] speed_cmd_o,
    input wire logic        led_o
);
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    logic        cond;
    // wide enough for the full-length blink timing, not only the short bench values
    logic [31:0] lit_cnt_r;
    logic [31:0] dark_cnt_r;
    logic        seen_lit_r;

    // overload needs a long run of load, so it is left to the bench
    assign cond = sensor_lost_i || (supply_mv_i >= mfa_pkg::OVERV_MV) || (supply_mv_i <= mfa_pkg::UNDERV_MV)
                  || (speed_meas_i > mfa_pkg::OVERSPD_RPM);

    always_ff @(posedge mclk_i) begin
        if (srst_i || fault_ok_o) begin
            lit_cnt_r  <= '0;
            dark_cnt_r <= '0;
            seen_lit_r <= 1'b0;
        end else if (led_o) begin
            lit_cnt_r  <= lit_cnt_r + 32'h1;
            dark_cnt_r <= '0;
            seen_lit_r <= 1'b1;
        end else begin
            lit_cnt_r  <= '0;
            dark_cnt_r <= dark_cnt_r + 32'h1;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    AST_FAULT_DROP: assert property (fault_ok_o && cond |-> ##[1:2] !fault_ok_o)
        else $error("fault status stayed on under a protection condition");
    AST_STOP_ON_FAULT: assert property (!fault_ok_o |-> !motor_run_o && hard_stop_o)
        else $error("motor not stopped while alarm latched");
    AST_LATCH: assert property (!fault_ok_o && !$fell(fault_clear_i) |=> !fault_ok_o)
        else $error("alarm left without a clear");
    AST_OK_DARK: assert property (fault_ok_o && $past(fault_ok_o) && $past(fault_ok_o, 2) |-> !led_o)
        else $error("led lit with no alarm");
    AST_LED_START: assert property ($fell(fault_ok_o) |=> led_o)
        else $error("led not lit after alarm");
    AST_ON_TIME: assert property ($fell(led_o) && !fault_ok_o |-> lit_cnt_r == LED_ON_CYC)
        else $error("led lit time wrong");
    AST_DARK_TIME: assert property ($rose(led_o) && seen_lit_r && !fault_ok_o
        |-> dark_cnt_r == LED_OFF_CYC || dark_cnt_r == LED_OFF_CYC + GROUP_GAP_CYC)
        else $error("led dark time wrong");
    AST_CLAMP: assert property (speed_cmd_o >= mfa_pkg::SPD_MIN_RPM && speed_cmd_o <= mfa_pkg::SPD_MAX_RPM)
        else $error("speed command out of range");
    AST_RUN_CAUSE: assert property (motor_run_o |-> $past(run_ramp_i) && $past(run_or_hard_stop_input_i))
        else $error("motor running without both run inputs");
    AST_CLEAR_REFUSED: assert property (!fault_ok_o && run_ramp_i && run_or_hard_stop_input_i |=> !fault_ok_o)
        else $error("clear taken with both run inputs on");
endmodule : mfa_checker

bind mfa_top mfa_checker #(
    .LED_ON_CYC   (LED_ON_CYC),
    .LED_OFF_CYC  (LED_OFF_CYC),
    .GROUP_GAP_CYC(GROUP_GAP_CYC)
) u_checker (
    .mclk_i                  (mclk_i),
    .srst_i                  (srst_i),
    .run_ramp_i              (run_ramp_i),
    .run_or_hard_stop_input_i(run_or_hard_stop_input_i),
    .fault_clear_i           (fault_clear_i),
    .sensor_lost_i           (sensor_lost_i),
    .supply_mv_i             (supply_mv_i),
    .speed_meas_i            (speed_meas_i),
    .fault_ok_o              (fault_ok_o),
    .motor_run_o             (motor_run_o),
    .hard_stop_o             (hard_stop_o),
    .speed_cmd_o             (speed_cmd_o),
    .led_o                   (led_o)
);

// ==== verification/mfa_ctrl_model.sv ====
// outside controller model: run, select and clear inputs, one change at a time
`timescale 1ns/1ps
module mfa_ctrl_model #(
    parameter int unsigned SPACE_CYC = 3
) (
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic        want_run_ramp_i,
    input  wire logic        want_run_hs_i,
    input  wire logic        want_sel_i,
    input  wire logic        want_open_i,
    input  wire logic        want_clear_i,
    input  wire logic [12:0] want_ext_mv_i,
    output logic             run_ramp_o,
    output logic             run_hs_o,
    output logic             sel_o,
    output logic             clear_o,
    output logic [12:0]      ext_mv_o
);
    logic sel_r;
    logic open_r;
    int   gap_r;

    // an open select line settles low through the board pull-down
    assign sel_o    = open_r ? 1'b0 : sel_r;
    assign ext_mv_o = (want_ext_mv_i > 13'h1388) ? 13'h1388 : want_ext_mv_i;

    // spacing scaled down from 10 ms to keep the run short
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            run_ramp_o <= 1'b0;
            run_hs_o   <= 1'b0;
            sel_r      <= 1'b0;
            open_r     <= 1'b1;
            clear_o    <= 1'b0;
            gap_r      <= 0;
        end else if (gap_r != 0) begin
            gap_r <= gap_r - 1;
        end else if (run_ramp_o != want_run_ramp_i) begin
            run_ramp_o <= want_run_ramp_i;
            gap_r      <= SPACE_CYC;
        end else if (run_hs_o != want_run_hs_i) begin
            run_hs_o <= want_run_hs_i;
            gap_r    <= SPACE_CYC;
        end else if ({open_r, sel_r} != {want_open_i, want_sel_i}) begin
            open_r <= want_open_i;
            sel_r  <= want_sel_i;
            gap_r  <= SPACE_CYC;
        end else if (clear_o != want_clear_i) begin
            clear_o <= want_clear_i;
            gap_r   <= SPACE_CYC;
        end
    end
endmodule : mfa_ctrl_model

// ==== verification/mfa_top_bench.sv ====
// self-checking bench: speed select, fault latch, coded led and clear
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module mfa_top_bench;
    localparam int unsigned ON = 4, OFF = 4, GAP = 12;
    logic        mclk_i = 1'b0, srst_i = 1'b1;
    logic        w_rr = 1'b0, w_rh = 1'b0, w_sel = 1'b0, w_open = 1'b1, w_clr = 1'b0;
    logic [12:0] w_ext = '0, ext, cmd, meas = '0;
    logic        rr, rh, sel, clr, load = 1'b0, lost = 1'b0, dir = 1'b0, dout;
    logic [15:0] supply = 16'h5dc0;
    logic [3:0]  adr = '0;
    logic        rd = 1'b0, wr = 1'b0, fault_ok, mrun, hstop, led, wreq;
    logic [31:0] wdat = '0, rdat;
    int          error_cnt = 0, checks = 0;

    initial forever #2.5 mclk_i = ~mclk_i;

    mfa_ctrl_model u_ctl (.mclk_i(mclk_i), .srst_i(srst_i), .want_run_ramp_i(w_rr), .want_run_hs_i(w_rh),
        .want_sel_i(w_sel), .want_open_i(w_open), .want_clear_i(w_clr), .want_ext_mv_i(w_ext),
        .run_ramp_o(rr), .run_hs_o(rh), .sel_o(sel), .clear_o(clr), .ext_mv_o(ext));

    mfa_top #(.LED_ON_CYC(ON), .LED_OFF_CYC(OFF), .GROUP_GAP_CYC(GAP), .OVERLOAD_CYC(20), .CHURN_WIN_CYC(50)) DUT (
        .mclk_i(mclk_i), .srst_i(srst_i), .run_ramp_i(rr), .run_or_hard_stop_input_i(rh), .dir_cw_i(dir),
        .speed_source_select_i(sel), .fault_clear_i(clr), .load_over_rated_i(load), .sensor_lost_i(lost),
        .supply_mv_i(supply), .speed_meas_i(meas), .ext_speed_mv_i(ext), .fault_ok_o(fault_ok),
        .motor_run_o(mrun), .hard_stop_o(hstop), .dir_cw_o(dout), .speed_cmd_o(cmd), .led_o(led),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq));

    // ------------------------------------------------------------
    // tasks and expectations
    // ------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    task automatic hang;
        error_cnt++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        print_verdict();
    endtask : hang

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : tick

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge mclk_i);
        rd   <= !w;
        wr   <= w;
        adr  <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50) hang();
    endtask : bus

    // wants are applied by the controller model at its own pace
    task automatic ctl(input logic a, input logic b, input logic s, input logic o, input logic c);
        int n;
        @(posedge mclk_i);
        w_rr   <= a;
        w_rh   <= b;
        w_sel  <= s;
        w_open <= o;
        w_clr  <= c;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while ({rr, rh, sel, clr} !== {a, b, s & !o, c} && n < 100);
        if (n >= 100) hang();
    endtask : ctl

    function automatic logic [12:0] clampv(input logic [31:0] v);
        return (v < 32'h64) ? 13'h0064 : (v > 32'hbb8) ? 13'h0bb8 : v[12:0];
    endfunction : clampv

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] q, w, x;
        int          k, rises, e;
        logic        prev;
        void'($urandom(32'h182b1311));
        repeat (6) @(posedge mclk_i);
        srst_i <= 1'b0;
        tick(2);
        `CHK({fault_ok, led, cmd}, {2'b10, 13'h0064})
        bus(1'b0, 4'h0, '0, q);
        `CHK(q[11:0], 12'h000)
        bus(1'b0, 4'hc, '0, q);
        `CHK(q, 32'h0)
        $display("reset and map test done");
        // mode 0 internal, 1 external driven, 2 select left open while on is wanted
        for (int m = 0; m < 3; m++) begin
            ctl(1'b0, 1'b0, m != 1, m == 2, 1'b0);
            for (int i = 0; i < 4; i++) begin
                w = (i == 0) ? 32'hfff : (i == 1) ? 32'h63 : $urandom_range(4095);
                x = (i == 0) ? 32'h1388 : $urandom_range(5000);
                w_ext <= x[12:0];
                bus(1'b1, 4'h0, w, q);
                tick(3);
                `CHK(cmd, clampv(m == 0 ? w : (x * 32'h999a) >> 16))
            end
            $display("speed select mode %0d done", m);
        end
        ctl(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        tick(3);
        `CHK({mrun, hstop, dout}, {2'b10, dir})
        for (int code = 1; code <= 6; code++) begin
            // code 1 is the churn form of overload: direction toggled every cycle
            e = (code == 1) ? 2 : code;
            case (code)
                1: dir <= 1'b1;
                2: load <= 1'b1;
                3: lost <= 1'b1;
                4: supply <= 16'h6bd0 + 16'($urandom_range(1) ? 0 : $urandom_range(900));
                5: supply <= 16'h4650 - 16'($urandom_range(1) ? 0 : $urandom_range(9000));
                default: meas <= 13'h0dad + 13'($urandom_range(400));
            endcase
            k = 0;
            while (fault_ok !== 1'b0 && k < 100) begin
                @(posedge mclk_i);
                k++;
                if (code == 1) dir <= !dir;
            end
            if (k >= 100) hang();
            `CHK({mrun, hstop}, 2'b01)
            rises = 0;
            prev = 1'b0;
            repeat (2 * (e * (ON + OFF) + GAP) - 4) begin
                @(posedge mclk_i);
                rises += (led && !prev);
                prev = led;
            end
            `CHK(rises, 2 * e)
            lost <= 1'b1;
            meas <= 13'h0fa0;
            bus(1'b0, 4'h4, '0, q);
            `CHK(q[4:0], {3'(e), 2'b10})
            load   <= 1'b0;
            lost   <= 1'b0;
            supply <= 16'h5dc0;
            meas   <= '0;
            ctl(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
            ctl(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
            tick(3);
            `CHK(fault_ok, 1'b0)
            ctl(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
            ctl(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
            tick(3);
            `CHK({fault_ok, led, dout}, {2'b10, dir})
            ctl(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
            $display("fault code %0d test done", code);
        end
        print_verdict();
    end
endmodule : mfa_top_bench
